// File: inc/nvm_map.vh
// register offsets, field positions, reset values and timing for the nvm block
`ifndef NVM_MAP_VH
`define NVM_MAP_VH
`define NVM_SECTOR_LO      1'b0
`define NVM_SECTOR_HI      1'b1
`define NVM_INDEX_OFS      8'h00
`define NVM_VALUE_OFS      8'h01
`define NVM_CONTROL_OFS    8'h40
`define NVM_CTL_FETCH_GO   0
`define NVM_CTL_FETCH_ARM  1
`define NVM_CTL_PROG_GO    2
`define NVM_CTL_PROG_ARM   3
`define NVM_RST_BYTE       8'h00
`define NVM_RST_CTL        4'h0
`define NVM_CLK_MHZ        200
`define NVM_PROG_TIME_US   2000
`define NVM_PROG_CYCLES    (`NVM_PROG_TIME_US * `NVM_CLK_MHZ)
`define NVM_FETCH_CYCLES   2
`endif

// File: src/nvm_access.v
// byte-wide non-volatile store with index, value and control registers
//
// Functional notes
// - 128 bytes, reached one byte per operation
// - index register holds 7 bits, bit 7 zero
// - control at 40h sector one, bits 3..0
// - program_go stores value, clears when done
// - program_go needs program_arm already set
// - fetch_go reads byte, clears, value register updated
// - fetch_go needs fetch_arm already set
// - cleared arm bits block their operations
// - value register holds read byte until next op
// - program time from independent timer count; modelled here by a PROG_CYCLES clock count
// - end of program sets irq and mf flags
// - vector only with all enables and stack room
// - service clears mf flag only, software clears irq
// - power-on clears control, index and value
`timescale 1ns/100ps
`include "nvm_map.vh"

module nvm_access #(
	parameter PROG_CYCLES  = `NVM_PROG_CYCLES,
	parameter FETCH_CYCLES = `NVM_FETCH_CYCLES,
	parameter DEPTH        = 128
) (
	input  wire       clock,
	input  wire       nrst,
	input  wire       reg_sector,
	input  wire [7:0] reg_addr,
	input  wire       reg_wr,
	input  wire [7:0] reg_wdata,
	output reg  [7:0] reg_rdata,
	input  wire       nvm_irq_flag_wr,
	input  wire       nvm_irq_flag_wdata,
	output wire       nvm_irq_flag,
	input  wire       nvm_irq_enable,
	input  wire       mf_irq_enable,
	input  wire       global_irq_enable,
	input  wire       stack_full,
	input  wire       irq_service,
	output wire       mf_irq_flag,
	output wire       irq_vector,
	output wire       busy
);

	localparam ST_IDLE  = 2'd0;
	localparam ST_PROG  = 2'd1;
	localparam ST_FETCH = 2'd2;

	// register decode, used for both write and read paths
	function hit;
		input       sec;
		input [7:0] adr;
		input       want_sec;
		input [7:0] want_adr;
		begin
			hit = (sec == want_sec) && (adr == want_adr);
		end
	endfunction

	reg [7:0]  mem_q [0:DEPTH-1];
	reg [6:0]  index_q;
	reg [7:0]  value_q;
	reg [3:0]  ctl_q;
	reg [1:0]  state_q;
	reg [31:0] cnt_q;
	reg        irq_q;
	reg        mf_q;
	reg        done_prog;
	reg        done_fetch;

	wire wr_index = reg_wr & hit(reg_sector, reg_addr,
		`NVM_SECTOR_LO, `NVM_INDEX_OFS);
	wire wr_value = reg_wr & hit(reg_sector, reg_addr,
		`NVM_SECTOR_LO, `NVM_VALUE_OFS);
	wire wr_ctl   = reg_wr & hit(reg_sector, reg_addr,
		`NVM_SECTOR_HI, `NVM_CONTROL_OFS);

	// go is honoured only when arm was already high before this write
	wire start_prog  = wr_ctl & reg_wdata[`NVM_CTL_PROG_GO] &
		ctl_q[`NVM_CTL_PROG_ARM] & (state_q == ST_IDLE);
	wire start_fetch = wr_ctl & reg_wdata[`NVM_CTL_FETCH_GO] &
		ctl_q[`NVM_CTL_FETCH_ARM] & (state_q == ST_IDLE) &
		~start_prog;

	// sequencer next state; the program length stands in for the
	// independent timer, so software must poll go or wait for the flag
	reg [1:0]  state_d;
	reg [31:0] cnt_d;
	reg        done_prog_d;
	reg        done_fetch_d;

	// last count of each cycle, sized to the counter on purpose
	wire [31:0] prog_last  = PROG_CYCLES - 1;
	wire [31:0] fetch_last = FETCH_CYCLES - 1;

	// end of the running cycle, true on its final counted clock
	wire prog_end  = (state_q == ST_PROG) && (cnt_q >= prog_last);
	wire fetch_end = (state_q == ST_FETCH) && (cnt_q >= fetch_last);

	// cycle sequencer; program length modelled by a clock count
	always @* begin
		state_d      = state_q;
		cnt_d        = cnt_q;
		done_prog_d  = 1'b0;
		done_fetch_d = 1'b0;
		case (state_q)
		ST_IDLE: begin
			cnt_d = 32'h0;
			if (start_prog)
				state_d = ST_PROG;
			else if (start_fetch)
				state_d = ST_FETCH;
		end
		ST_PROG: begin
			if (prog_end) begin
				state_d     = ST_IDLE;
				done_prog_d = 1'b1;
			end else begin
				cnt_d = cnt_q + 32'h1;
			end
		end
		ST_FETCH: begin
			if (fetch_end) begin
				state_d      = ST_IDLE;
				done_fetch_d = 1'b1;
			end else begin
				cnt_d = cnt_q + 32'h1;
			end
		end
		default: begin
			state_d = ST_IDLE;
			cnt_d   = 32'h0;
		end
		endcase
	end

	// state and counter registers
	always @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			state_q <= ST_IDLE;
			cnt_q   <= 32'h0;
		end else begin
			state_q <= state_d;
			cnt_q   <= cnt_d;
		end
	end

	// completion strobes stand for one cycle, just after busy falls
	always @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			done_prog  <= 1'b0;
			done_fetch <= 1'b0;
		end else begin
			done_prog  <= done_prog_d;
			done_fetch <= done_fetch_d;
		end
	end

	// array store; no reset, contents are non-volatile
	always @(posedge clock) begin
		if (done_prog)
			mem_q[index_q] <= value_q;
	end

	// next index and value; software writes are refused mid-cycle so
	// the byte being stored or fetched cannot move under the array
	reg [6:0] index_d;
	reg [7:0] value_d;

	always @* begin
		index_d = index_q;
		if (wr_index && state_q == ST_IDLE)
			index_d = reg_wdata[6:0];
	end

	// read result overrides software; held until next op
	always @* begin
		value_d = value_q;
		if (done_fetch)
			value_d = mem_q[index_q];
		else if (wr_value && state_q == ST_IDLE)
			value_d = reg_wdata;
	end

	// index and value registers
	always @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			index_q <= 7'h00;
			value_q <= `NVM_RST_BYTE;
		end else begin
			index_q <= index_d;
			value_q <= value_d;
		end
	end

	// control bits: a write taken while idle replaces all four, and a
	// finished cycle clears only its own go bit
	localparam [3:0] CTL_RST  = `NVM_RST_CTL;
	wire             ctl_take = wr_ctl && (state_q == ST_IDLE);
	wire [3:0]       ctl_wval;
	wire [3:0]       ctl_done;
	wire [3:0]       ctl_d;

	// value a taken write leaves; go only sticks when armed before
	assign ctl_wval[`NVM_CTL_PROG_ARM]  = reg_wdata[`NVM_CTL_PROG_ARM];
	assign ctl_wval[`NVM_CTL_PROG_GO]   = start_prog;
	assign ctl_wval[`NVM_CTL_FETCH_ARM] = reg_wdata[`NVM_CTL_FETCH_ARM];
	assign ctl_wval[`NVM_CTL_FETCH_GO]  = start_fetch;

	// hardware clear per bit; arm bits are left to software
	assign ctl_done[`NVM_CTL_PROG_ARM]  = 1'b0;
	assign ctl_done[`NVM_CTL_PROG_GO]   = done_prog;
	assign ctl_done[`NVM_CTL_FETCH_ARM] = 1'b0;
	assign ctl_done[`NVM_CTL_FETCH_GO]  = done_fetch;

	// a write taken on the clear edge carries its own go decision, so
	// a finished go bit can only come back through a fresh armed start
	genvar b;
	generate
		for (b = 0; b < 4; b = b + 1) begin : g_ctl
			assign ctl_d[b] = ctl_take ? ctl_wval[b] :
				(ctl_done[b] ? 1'b0 : ctl_q[b]);
		end
	endgenerate

	// control register
	always @(posedge clock or negedge nrst) begin
		if (!nrst)
			ctl_q <= CTL_RST;
		else
			ctl_q <= ctl_d;
	end

	// interrupt flag next values; set beats a same-cycle clear, so an
	// end of program is never lost to a software write
	reg irq_d;
	reg mf_d;

	always @* begin
		irq_d = irq_q;
		if (done_prog)
			irq_d = 1'b1;
		else if (nvm_irq_flag_wr)
			irq_d = nvm_irq_flag_wdata;
	end

	// service clears only the shared request, never the block's flag
	always @* begin
		mf_d = mf_q;
		if (done_prog)
			mf_d = 1'b1;
		else if (irq_service)
			mf_d = 1'b0;
	end

	// block flag register
	always @(posedge clock or negedge nrst) begin
		if (!nrst)
			irq_q <= 1'b0;
		else
			irq_q <= irq_d;
	end

	// shared request register
	always @(posedge clock or negedge nrst) begin
		if (!nrst)
			mf_q <= 1'b0;
		else
			mf_q <= mf_d;
	end

	assign nvm_irq_flag = irq_q;
	assign mf_irq_flag  = mf_q;

	// vector needs every enable and room on the return stack
	assign irq_vector   = mf_q & irq_q & global_irq_enable &
		nvm_irq_enable & mf_irq_enable & ~stack_full;

	// busy covers the timed cycle; go clears one edge after it falls
	assign busy = (state_q != ST_IDLE);

	// read-side selects, decoded once for the mux below
	wire rd_index = hit(reg_sector, reg_addr,
		`NVM_SECTOR_LO, `NVM_INDEX_OFS);
	wire rd_value = hit(reg_sector, reg_addr,
		`NVM_SECTOR_LO, `NVM_VALUE_OFS);
	wire rd_ctl   = hit(reg_sector, reg_addr,
		`NVM_SECTOR_HI, `NVM_CONTROL_OFS);

	// read mux; unused bits and unmapped addresses read zero
	always @* begin
		reg_rdata = 8'h00;
		if (rd_index)
			reg_rdata = {1'b0, index_q};
		else if (rd_value)
			reg_rdata = value_q;
		else if (rd_ctl)
			reg_rdata = {4'h0, ctl_q};
	end

endmodule

// File: tb/nvm_cpu.sv
// cpu model running firmware sequences on the register port
`timescale 1ns/100ps
module nvm_cpu (
	input  logic       clock,
	input  logic       busy,
	input  logic [7:0] rd,
	output logic       sec,
	output logic [7:0] adr,
	output logic       wr,
	output logic [7:0] wd
);
	initial {sec, adr, wr, wd} = 18'h0;
	// one write; consecutive calls give back-to-back writes
	task put(input logic s, input logic [7:0] a, d);
		@(negedge clock);
		{sec, adr, wr, wd} = {s, a, 1'b1, d};
	endtask
	// released data shows the inverse, never the old byte
	task rel();
		@(negedge clock);
		wr = 0;
		wd = ~wd;
	endtask
	task get(input logic s, input logic [7:0] a, output logic [7:0] v);
		@(negedge clock);
		{sec, adr} = {s, a};
		#1 v = rd;
	endtask
	// p: program byte d at a, else fetch a; arm then go, never both go
	task op(input logic p, input logic [6:0] a, input logic [7:0] d);
		put(0, 8'h00, {1'b0, a});
		if (p)
			put(0, 8'h01, d);
		put(1, 8'h40, p ? 8'h08 : 8'h02);
		put(1, 8'h40, p ? 8'h0c : 8'h03);
		rel();
		while (busy)
			@(negedge clock);
		put(1, 8'h40, 8'h00);
		rel();
	endtask
endmodule

// File: tb/nvm_access_assertions.sv
// port checks for the nvm access block
`timescale 1ns/100ps
module nvm_access_assertions #(
	parameter PROG_CYCLES  = 8,
	parameter FETCH_CYCLES = 2
) (
	input logic       clock,
	input logic       nrst,
	input logic       reg_sector,
	input logic [7:0] reg_addr,
	input logic       reg_wr,
	input logic [7:0] reg_wdata,
	input logic [7:0] reg_rdata,
	input logic       nvm_irq_flag_wr,
	input logic       nvm_irq_flag,
	input logic       nvm_irq_enable,
	input logic       mf_irq_enable,
	input logic       global_irq_enable,
	input logic       stack_full,
	input logic       irq_service,
	input logic       mf_irq_flag,
	input logic       irq_vector,
	input logic       busy
);
	int  n;
	wire ctl = reg_sector && reg_addr == 8'h40;
	// length of each busy run, judged when it ends
	always @(posedge clock or negedge nrst)
		if (!nrst)
			n <= 0;
		else
			n <= busy ? n + 1 : 0;
	default clocking @(posedge clock); endclocking
	default disable iff (!nrst);
	a_busy_cause: assert property ($rose(busy) |->
		$past(reg_wr && ctl && (reg_rdata[3] && reg_wdata[2] ||
		reg_rdata[1] && reg_wdata[0]))) else $error("cycle without arm");
	a_prog_len: assert property ($rose(nvm_irq_flag) |->
		!busy && $past(n) == PROG_CYCLES) else $error("program length");
	a_fetch_len: assert property ($past($fell(busy)) &&
		!nvm_irq_flag |-> $past(n) == FETCH_CYCLES)
		else $error("fetch length");
	a_mf_with: assert property ($rose(nvm_irq_flag) |->
		mf_irq_flag) else $error("mf flag not set");
	a_flag_hold: assert property (nvm_irq_flag &&
		!nvm_irq_flag_wr |=> nvm_irq_flag) else $error("flag lost");
	a_mf_clear: assert property (irq_service && !busy |=>
		!mf_irq_flag) else $error("mf flag kept");
	a_ctl_top: assert property (ctl |-> reg_rdata[7:4] == 4'h0)
		else $error("control top bits");
	a_vec_gate: assert property (irq_vector |->
		global_irq_enable && nvm_irq_enable && mf_irq_enable &&
		!stack_full && mf_irq_flag) else $error("vector gate");
endmodule
bind nvm_access nvm_access_assertions #(.PROG_CYCLES(PROG_CYCLES),
	.FETCH_CYCLES(FETCH_CYCLES)) i_nvm_access_assertions (.clock, .nrst,
	.reg_sector, .reg_addr, .reg_wr, .reg_wdata, .reg_rdata,
	.nvm_irq_flag_wr, .nvm_irq_flag, .nvm_irq_enable, .mf_irq_enable,
	.global_irq_enable, .stack_full, .irq_service, .mf_irq_flag,
	.irq_vector, .busy);

// File: tb/tb_nvm_access.sv
// self-checking bench for the nvm access block
`timescale 1ns/100ps
module tb_nvm_access;
	logic       clock, nrst, sec, wr, fwr, ne, me, ge, sf, svc, g;
	logic [7:0] adr, wd, rd, v;
	wire        fl, mf, vec, busy;
	int         fails, cmp_count, cyc, a, d, i, m[128];
	bit  [31:0] seed = 78129;
	nvm_access #(.PROG_CYCLES(8)) i_nvm_access (.clock(clock), .nrst(nrst),
		.reg_sector(sec), .reg_addr(adr), .reg_wr(wr), .reg_wdata(wd),
		.reg_rdata(rd), .nvm_irq_flag_wr(fwr), .nvm_irq_flag_wdata(1'b0),
		.nvm_irq_flag(fl), .nvm_irq_enable(ne), .mf_irq_enable(me),
		.global_irq_enable(ge), .stack_full(sf), .irq_service(svc),
		.mf_irq_flag(mf), .irq_vector(vec), .busy(busy));
	nvm_cpu i_nvm_cpu (.clock(clock), .busy(busy), .rd(rd), .sec(sec),
		.adr(adr), .wr(wr), .wd(wd));
	function bit [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task chk(input string n, input logic [7:0] s, e);
		cmp_count++;
		if (s !== e) begin
			fails++;
			$display("wrong value %s exp %h seen %h", n, e, s);
		end
	endtask
	task end_sim();
		if (fails == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial begin
		clock = 0;
		forever #2.5 clock = ~clock;
	end
	// hang guard, far above the 160 or so cycles the run needs
	always @(posedge clock) begin
		cyc++;
		if (cyc == 20000) begin
			fails++;
			end_sim();
		end
	end
	initial begin
		{nrst, fwr, ne, me, ge, sf, svc} = 7'h0;
		repeat (20) @(negedge clock);
		nrst = 1;
		for (a = 0; a < 3; a++) begin
			i_nvm_cpu.get(a == 2, a == 2 ? 8'h40 : 8'(a), v);
			chk("reset", v, 8'h00);
		end
		// stray top bits of index and control: only arm bits and low index stick
		i_nvm_cpu.put(0, 8'h00, 8'hff);
		i_nvm_cpu.put(1, 8'h40, 8'hf2);
		i_nvm_cpu.rel();
		i_nvm_cpu.get(0, 8'h00, v);
		chk("index", v, 8'h7f);
		i_nvm_cpu.get(1, 8'h40, v);
		chk("control", v, 8'h02);
		for (i = 0; i < 2; i++) begin
			i_nvm_cpu.put(1, 8'h40, i ? 8'h01 : 8'h04);
			i_nvm_cpu.rel();
			i_nvm_cpu.get(1, 8'h40, v);
			chk("unarmed go", v, 8'h00);
			chk("unarmed busy", busy, 8'h00);
		end
		for (i = 0; i < 4; i++) begin
			a = rnd() % 128;
			d = rnd() % 256;
			{ne, me, g, sf} = i ? 4'(rnd()) : 4'he;
			ge = 0;
			i_nvm_cpu.op(1, 7'(a), 8'(d));
			ge = g;
			m[a] = d;
			chk("flags", {fl, mf}, 8'h03);
			@(negedge clock);
			chk("vector", vec, 8'(ne & me & ge & !sf));
			@(negedge clock) svc = 1;
			@(negedge clock) svc = 0;
			chk("service", {fl, mf}, 8'h02);
			@(negedge clock) fwr = 1;
			@(negedge clock) fwr = 0;
			i_nvm_cpu.op(0, 7'(a), 8'h00);
			i_nvm_cpu.get(0, 8'h01, v);
			chk("fetch", v, 8'(m[a]));
			i_nvm_cpu.put(0, 8'h00, 8'(a + 1));
			i_nvm_cpu.rel();
			i_nvm_cpu.get(0, 8'h01, v);
			chk("held", v, 8'(m[a]));
			chk("flag cleared", fl, 8'h00);
		end
		end_sim();
	end
endmodule
